// File: design/flash_bus_pkg.sv
// Constants shared by the flash pin-level bus interface.
// Assumes a 40 MHz system clock and an APB register port.
package flash_bus_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADDR   = 8'h08;

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  localparam int CFG_SYNC     = 0;
  localparam int CFG_LATCH    = 1;
  localparam int CFG_FALLING  = 2;
  localparam int CFG_CONT     = 3;
  localparam int CFG_EARLY    = 4;
  localparam int CFG_MIDFREQ  = 5;
  localparam int CFG_XLAT_LO  = 6;
  localparam int CFG_YLAT_LO  = 9;
  localparam int CFG_W        = 12;
  localparam logic [11:0] CFG_RESET = 12'h000;

  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int ST_BUSY      = 0;
  localparam int ST_SUSP      = 1;
  localparam int ST_VPP_ERR   = 3;
  localparam int ST_CFG_DONE  = 4;
  localparam int ST_UNPROT    = 5;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int GLITCH_NS     = 5;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABORT_CYC     = 8;

  // ----------------------------------------
  // Program/erase commands and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_PROG,
    CMD_ERASE,
    CMD_SUSPEND,
    CMD_RESUME
  } cmd_e;

  typedef enum logic [1:0] {
    PE_IDLE,
    PE_RUN,
    PE_SUSP,
    PE_ABORT
  } pe_state_e;

endpackage : flash_bus_pkg

// File: design/pin_filter.sv
// Two-stage synchroniser with a stability filter for pin inputs.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter int          W    = 1,
  parameter int          HOLD = 0,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  // Pins
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] prev_reg;
  logic [7:0]   cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= RST;
      s2_reg <= RST;
    end else if (clk_en) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
    end
  end

  // Pass a value only once it has stood HOLD cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= RST;
      cnt_reg  <= 8'h00;
      level    <= RST;
    end else if (clk_en) begin
      prev_reg <= s2_reg;
      if (s2_reg != prev_reg) begin
        cnt_reg <= 8'h00;
      end else if (cnt_reg < 8'(HOLD)) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      if (s2_reg == prev_reg && cnt_reg >= 8'(HOLD)) begin
        level <= s2_reg;
      end
    end
  end
endmodule : pin_filter
`default_nettype wire

// File: design/flash_bus_interface_control.sv
// Pin-level bus interface of a parallel burst flash, device side.
// Assumes pins asynchronous to clk, core logic on clk, APB registers.
// Function
// RULE1: High voltage on reset pin unprotects every block temporarily.
// RULE2: System should tie reset pin to processor reset.
// RULE3: Latch mode captures address at latch strobe rise; transparent while low.
// RULE4: Sync burst latches address at first active edge or strobe rise.
// RULE5: Active clock edge selectable; clock ignored in async operations.
// RULE6: Advance sampled only after latency; low steps burst counter.
// RULE7: Advance high holds counter and data until next latency expires.
// RULE8: Valid-ready driven only in continuous synchronous burst reads.
// RULE9: Valid-ready low flags invalid data; optionally one cycle early.
// RULE10: Mid-frequency with latency 2 ignores advance on odd cycles.
// RULE11: Width select low: 16-bit bus, upper lines floating, A1 lsb.
// RULE12: Width select high: 32-bit bus, A2 lsb, A1 ignored.
// RULE13: Busy output pulled low while program/erase controller runs.
// RULE14: While busy only suspend is accepted among program/erase commands.
// RULE15: Busy asserts on reset only if controller was running.
// RULE16: Enable low turns program/erase into error flag bit 3.
// RULE17: System keeps program/erase enable high during operations.
// RULE18: After reset only async modes until configuration is written.
// RULE19: Internal registers always read with async behaviour.
// RULE20: Pulses under 5 ns on chip or write enable ignored.
// RULE21: Async read drives array data or selected internal register.
// RULE22: Data floats when deselected or disabled; busy shows on DQ7.
// RULE23: Reset pin low clears status, deselects, aborts operations.
// RULE24: Each accepted advance steps one unit of bus width.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_interface_control
  import flash_bus_pkg::*;
(
  // System
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins
  input  wire logic [23:1] addr,
  input  wire logic        chip_en_n,
  input  wire logic        out_en_n,
  input  wire logic        wr_en_n,
  input  wire logic        latch_n,
  input  wire logic        bus_clk,
  input  wire logic        adv_n,
  input  wire logic        word_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        unprotect_high_voltage,
  input  wire logic        vpp_en,
  output logic      [31:0] dq_out,
  output logic      [31:0] dq_oe,
  output logic             valid_ready_out,
  output logic             valid_ready_oe,
  output logic             busy_out_n,
  output logic             busy_oe,
  // Memory core
  input  wire logic [31:0] core_rdata,
  input  wire logic        core_internal,
  input  wire logic        cmd_valid,
  input  wire cmd_e        cmd_code,
  input  wire logic        pe_done,
  output logic      [23:1] mem_addr,
  output logic             pe_start,
  output logic             pe_abort,
  output logic             unprotect_all
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0]  strobe_s;
  logic [7:0]  ctl_s;
  logic [23:1] addr_s;
  logic        ce_n_s;
  logic        we_n_s;
  logic        oe_n_s;
  logic        l_n_s;
  logic        k_s;
  logic        b_n_s;
  logic        word_s;
  logic        rp_n_s;

  pin_filter #(.W(2), .HOLD(GLITCH_CYC), .RST(2'b11)) u_strobe_filter ( // RULE20
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .pin    ({chip_en_n, wr_en_n}),
    .level  (strobe_s)
  );

  pin_filter #(.W(8), .HOLD(0), .RST(8'h0f)) u_ctl_sync (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .pin    ({vpp_en, unprotect_high_voltage, word_n, bus_clk,
              reset_powerdown_n, adv_n, latch_n, out_en_n}),
    .level  (ctl_s)
  );

  pin_filter #(.W(23), .HOLD(0), .RST(23'h000000)) u_addr_sync (
    .clk    (clk),
    .rst    (rst),
    .clk_en (clk_en),
    .pin    (addr),
    .level  (addr_s)
  );

  assign ce_n_s = strobe_s[1];
  assign we_n_s = strobe_s[0];
  assign oe_n_s = ctl_s[0];
  assign l_n_s  = ctl_s[1];
  assign b_n_s  = ctl_s[2];
  assign rp_n_s = ctl_s[3];
  assign k_s    = ctl_s[4];
  assign word_s = ctl_s[5];

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [11:0] cfg_reg;
  logic        cfg_done_reg;
  logic        vpp_err_reg;
  pe_state_e   pe_reg;
  logic [3:0]  abort_cnt_reg;
  logic [23:1] lat_addr_reg;
  logic [23:1] burst_addr_reg;
  logic        started_reg;
  logic        l_prev_reg;
  logic        k_prev_reg;
  logic [2:0]  lat_cnt_reg;
  logic        first_read_reg;
  logic        odd_reg;

  // Width-aware address masking and latency counter reload
  function automatic logic [23:1] mask_a1(input logic [23:1] a, input logic x32);
    mask_a1 = x32 ? {a[23:2], 1'b0} : a;
  endfunction : mask_a1

  function automatic logic [2:0] reload(input logic [2:0] y);
    reload = (y == 3'd0) ? 3'd0 : y - 3'd1;
  endfunction : reload

  logic        x32;
  logic        apb_wr;
  logic        apb_rd;
  logic        sync_on;
  logic        latch_on;
  logic        k_active;
  logic        l_rise;
  logic        rd_cycle;
  logic        start_now;
  logic [2:0]  x_lat;
  logic [2:0]  y_lat;
  logic        adv_ignore;
  logic        inv_now;
  logic        inv_next;
  logic        busy;
  logic [23:1] async_addr;

  assign x32      = word_s;                                              // RULE12
  assign apb_wr   = psel & penable & pwrite & ~pready;
  assign apb_rd   = psel & penable & ~pwrite & ~pready;
  assign sync_on  = cfg_reg[CFG_SYNC] & cfg_done_reg & ~core_internal;  // RULE18 RULE19
  assign latch_on = cfg_reg[CFG_LATCH] & cfg_done_reg & ~core_internal; // RULE18 RULE19
  assign k_active = sync_on & (cfg_reg[CFG_FALLING] ? (k_prev_reg & ~k_s)
                                                    : (~k_prev_reg & k_s)); // RULE5
  assign l_rise   = ~l_prev_reg & l_n_s;
  assign rd_cycle = rp_n_s & ~ce_n_s & we_n_s;
  assign start_now = sync_on & rd_cycle & ~started_reg
                     & ((k_active & ~l_n_s) | l_rise);                   // RULE4
  assign x_lat    = cfg_reg[CFG_XLAT_LO +: 3];
  assign y_lat    = cfg_reg[CFG_YLAT_LO +: 3];
  assign adv_ignore = cfg_reg[CFG_MIDFREQ] & (y_lat == 3'd2) & odd_reg; // RULE10
  assign inv_now  = lat_cnt_reg != 3'd0;
  assign inv_next = (lat_cnt_reg > 3'd1) | ((lat_cnt_reg == 3'd0) & (y_lat > 3'd1));
  assign busy     = (pe_reg == PE_RUN) | (pe_reg == PE_ABORT);
  assign async_addr = mask_a1(latch_on ? lat_addr_reg : addr_s, x32);   // RULE11 RULE12

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= apb_wr | apb_rd;
      pslverr <= (apb_wr | apb_rd) & ~(paddr == OFS_CFG | paddr == OFS_STATUS
                                      | paddr == OFS_ADDR);
      if (apb_rd) begin
        case (paddr)
          OFS_CFG:    prdata <= {20'h00000, cfg_reg};
          OFS_STATUS: prdata <= {26'h0000000, unprotect_all, cfg_done_reg,
                                 vpp_err_reg, 1'b0, pe_reg == PE_SUSP, busy};
          OFS_ADDR:   prdata <= {8'h00, burst_addr_reg, 1'b0};
          default:    prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Burst configuration; pin reset returns to async defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg      <= CFG_RESET;
      cfg_done_reg <= 1'b0;
    end else if (clk_en) begin
      if (~rp_n_s) begin
        cfg_reg      <= CFG_RESET;                                       // RULE18
        cfg_done_reg <= 1'b0;
      end else if (apb_wr && paddr == OFS_CFG) begin
        cfg_reg      <= pwdata[CFG_W-1:0];
        cfg_done_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Program/erase control
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pe_reg        <= PE_IDLE;
      abort_cnt_reg <= 4'h0;
      pe_start      <= 1'b0;
      pe_abort      <= 1'b0;
    end else if (clk_en) begin
      pe_start <= 1'b0;
      pe_abort <= 1'b0;
      if (~rp_n_s) begin
        if (pe_reg == PE_RUN || pe_reg == PE_SUSP) begin
          pe_reg        <= (pe_reg == PE_RUN) ? PE_ABORT : PE_IDLE;     // RULE15
          abort_cnt_reg <= 4'(ABORT_CYC);
          pe_abort      <= 1'b1;                                         // RULE23
        end else if (pe_reg == PE_ABORT) begin
          abort_cnt_reg <= abort_cnt_reg - 4'h1;
          if (abort_cnt_reg == 4'h1) begin
            pe_reg <= PE_IDLE;
          end
        end
      end else begin
        case (pe_reg)
          PE_IDLE: begin
            if (cmd_valid && (cmd_code == CMD_PROG || cmd_code == CMD_ERASE)
                && ctl_s[7]) begin                                        // RULE16
              pe_reg   <= PE_RUN;
              pe_start <= 1'b1;
            end
          end
          PE_RUN: begin
            if (pe_done) begin
              pe_reg <= PE_IDLE;
            end else if (cmd_valid && cmd_code == CMD_SUSPEND) begin     // RULE14
              pe_reg <= PE_SUSP;
            end
          end
          PE_SUSP: begin
            if (cmd_valid && cmd_code == CMD_RESUME) begin
              pe_reg <= PE_RUN;
            end
          end
          PE_ABORT: begin
            abort_cnt_reg <= abort_cnt_reg - 4'h1;
            if (abort_cnt_reg <= 4'h1) begin
              pe_reg <= PE_IDLE;
            end
          end
          default: pe_reg <= PE_IDLE;
        endcase
      end
    end
  end

  // Enable-low error flag; new error wins over software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vpp_err_reg <= 1'b0;
    end else if (clk_en) begin
      if (~rp_n_s) begin
        vpp_err_reg <= 1'b0;                                             // RULE23
      end else if (cmd_valid && (cmd_code == CMD_PROG || cmd_code == CMD_ERASE)
                   && !ctl_s[7] && pe_reg != PE_RUN) begin
        vpp_err_reg <= 1'b1;                                             // RULE16
      end else if (apb_wr && paddr == OFS_STATUS && pwdata[ST_VPP_ERR]) begin
        vpp_err_reg <= 1'b0;
      end
    end
  end

  // Busy pin pulled low while controller runs or aborts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_out_n    <= 1'b0;
      busy_oe       <= 1'b0;
      unprotect_all <= 1'b0;
    end else if (clk_en) begin
      busy_oe       <= busy;                                             // RULE13
      unprotect_all <= ctl_s[6];                                         // RULE1
    end
  end

  // ----------------------------------------
  // Address latch and burst counter
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_addr_reg <= 23'h000000;
      l_prev_reg   <= 1'b1;
      k_prev_reg   <= 1'b0;
    end else if (clk_en) begin
      l_prev_reg <= l_n_s;
      k_prev_reg <= k_s;
      if (~l_n_s) begin
        lat_addr_reg <= addr_s;                                          // RULE3
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_addr_reg <= 23'h000000;
      started_reg    <= 1'b0;
      lat_cnt_reg    <= 3'd0;
      first_read_reg <= 1'b0;
      odd_reg        <= 1'b0;
    end else if (clk_en) begin
      if (!sync_on || !rd_cycle) begin
        started_reg    <= 1'b0;                                          // RULE23
        first_read_reg <= 1'b0;
        odd_reg        <= 1'b0;
      end else if (start_now) begin
        started_reg    <= 1'b1;
        burst_addr_reg <= mask_a1(l_rise ? lat_addr_reg : addr_s, x32);  // RULE4
        lat_cnt_reg    <= x_lat;
      end else if (started_reg && k_active) begin
        if (first_read_reg) begin
          odd_reg <= ~odd_reg;
        end
        if (inv_now) begin
          lat_cnt_reg <= lat_cnt_reg - 3'd1;                             // RULE6
        end else begin
          first_read_reg <= 1'b1;
          lat_cnt_reg    <= reload(y_lat);                               // RULE7
          if (!b_n_s && !adv_ignore) begin
            burst_addr_reg <= burst_addr_reg + (x32 ? 23'h000002 : 23'h000001); // RULE24
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Data bus and valid-ready drive
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_addr <= 23'h000000;
    end else if (clk_en) begin
      mem_addr <= started_reg ? burst_addr_reg : async_addr;             // RULE19 RULE21
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_out <= 32'h00000000;
      dq_oe  <= 32'h00000000;
    end else if (clk_en) begin
      if (!(rd_cycle && !oe_n_s)) begin
        dq_out <= 32'h00000000;
        dq_oe  <= 32'h00000000;                                          // RULE22
      end else if (busy) begin
        dq_out <= 32'h00000000;
        dq_oe  <= 32'h00000080;                                          // RULE22
      end else begin
        dq_out <= core_rdata;                                            // RULE21
        dq_oe  <= x32 ? 32'hffffffff : 32'h0000ffff;                     // RULE11
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_ready_out <= 1'b0;
      valid_ready_oe  <= 1'b0;
    end else if (clk_en) begin
      valid_ready_oe <= started_reg & cfg_reg[CFG_CONT]                  // RULE8
                        & (cfg_reg[CFG_EARLY] ? inv_next : inv_now);     // RULE9
    end
  end
endmodule : flash_bus_interface_control
`default_nettype wire

// File: tb/flash_bus_interface_control_asserts.sv
// Port assertions for the flash pin-level bus interface.
// Assumes it is bound onto the top module, with clk_en normally high.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_checker
  import flash_bus_pkg::*;
(
  // System
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        pready,
  // Pins
  input wire logic        chip_en_n,
  input wire logic        word_n,
  input wire logic        reset_powerdown_n,
  input wire logic        unprotect_high_voltage,
  input wire logic        vpp_en,
  input wire logic [31:0] dq_oe,
  input wire logic        valid_ready_out,
  input wire logic        busy_out_n,
  input wire logic        busy_oe,
  // Core
  input wire logic        cmd_valid,
  input wire cmd_e        cmd_code,
  input wire logic [23:1] mem_addr,
  input wire logic        pe_start,
  input wire logic        unprotect_all
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !clk_en);

  property p_vr_od; valid_ready_out == 1'b0; endproperty
  a_vr_od: assert property (p_vr_od) else $error("valid ready drives high");
  property p_busy_od; busy_out_n == 1'b0; endproperty
  a_busy_od: assert property (p_busy_od) else $error("busy drives high");
  property p_start_busy; pe_start |-> ##[1:2] busy_oe; endproperty
  a_start_busy: assert property (p_start_busy) else $error("no busy after start");
  property p_busy_reject;
    busy_oe && cmd_valid && cmd_code != CMD_SUSPEND |=> !pe_start;
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("start while busy");
  property p_vpp_block;
    (!vpp_en)[*6] ##0 (cmd_valid && cmd_code inside {CMD_PROG, CMD_ERASE}) |=> !pe_start;
  endproperty
  a_vpp_block: assert property (p_vpp_block) else $error("start with enable low");
  property p_hv; (unprotect_high_voltage && reset_powerdown_n)[*6] |-> unprotect_all; endproperty
  a_hv: assert property (p_hv) else $error("no unprotect on high voltage");
  property p_x16; (!word_n)[*8] |-> dq_oe[31:16] == 16'h0000; endproperty
  a_x16: assert property (p_x16) else $error("upper lines driven in x16");
  property p_x32; word_n[*8] |-> !mem_addr[1]; endproperty
  a_x32: assert property (p_x32) else $error("A1 used in x32");
  property p_desel; chip_en_n[*8] |-> dq_oe == 32'h0000_0000; endproperty
  a_desel: assert property (p_desel) else $error("data driven while deselected");
  property p_rpd; (!reset_powerdown_n)[*6] |-> dq_oe == 32'h0000_0000; endproperty
  a_rpd: assert property (p_rpd) else $error("data driven in pin reset");

  c_start: cover property (pe_start);
  c_unprot: cover property (unprotect_all);
  c_apb: cover property (pready);
endmodule : flash_bus_checker
`default_nettype wire

// File: tb/flash_host_model.sv
// Host bus model driving the flash pins.
// Assumes clk is the system clock; the link clock runs only in frames.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // System
  input  wire logic        clk,
  input  wire logic        rst,
  // Pins
  output logic      [23:1] addr,
  output logic             chip_en_n,
  output logic             out_en_n,
  output logic             wr_en_n,
  output logic             bus_clk,
  output logic             word_n,
  output logic             reset_powerdown_n,
  output logic             unprotect_high_voltage,
  output logic             vpp_en
);
  logic frame;
  logic pin_rst;

  initial begin
    {chip_en_n, out_en_n, wr_en_n} = 3'h7;
    {addr, bus_clk, word_n, reset_powerdown_n} = '0;
    {unprotect_high_voltage, vpp_en, frame, pin_rst} = '0;
  end
  always #100 bus_clk = frame ? ~bus_clk : 1'b0;
  always @(posedge clk) reset_powerdown_n <= !rst && !pin_rst;

  task read_cycle(input logic [23:1] a, input logic w);
    @(posedge clk);
    addr <= a;
    word_n <= w;
    {chip_en_n, out_en_n, wr_en_n, frame} <= 4'h3;
  endtask : read_cycle

  task end_cycle();
    @(posedge clk);
    {chip_en_n, out_en_n, frame} <= 3'h6;
    addr <= ~addr;
  endtask : end_cycle

  task set_pins(input logic vpp, input logic hv, input logic prst);
    @(posedge clk);
    vpp_en <= vpp;
    unprotect_high_voltage <= hv;
    pin_rst <= prst;
  endtask : set_pins
endmodule : flash_host_model
`default_nettype wire

// File: tb/test_flash_bus_interface_control.sv
// Self-checking bench for the flash pin-level bus interface.
// Assumes the host model drives pins and the bench drives APB and core.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_flash_bus_interface_control
  import flash_bus_pkg::*;
;
  logic clk = 0, rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, dq_out, dq_oe, core_rdata, rd;
  logic pready, pslverr, err, vr_out, vr_oe, busy_n, busy_oe, bclk, word_n;
  logic ce_n, oe_n, we_n, rp_n, hv, vpp, cmd_valid = 0, pe_done = 0, bn = 1;
  logic pe_start, pe_abort, unprot;
  logic [23:1] addr, mem_addr;
  cmd_e cmd_code = CMD_PROG;
  int bad_count = 0, n_compared = 0, starts = 0, aborts = 0;
  typedef struct packed { logic w; logic [23:1] a; } row_s;
  row_s rows [4] = '{'{1'b0, 23'h00_0005}, '{1'b0, 23'h12_3456},
                     '{1'b1, 23'h01_2345}, '{1'b1, 23'h7f_ffff}};

  always #12.5 clk = ~clk;
  assign core_rdata = {mem_addr[16:1], ~mem_addr[16:1]};
  always @(posedge clk) begin
    starts += (pe_start === 1'b1);
    aborts += (pe_abort === 1'b1);
  end

  flash_host_model host_u (.clk(clk), .rst(rst), .addr(addr), .chip_en_n(ce_n),
    .out_en_n(oe_n), .wr_en_n(we_n), .bus_clk(bclk), .word_n(word_n),
    .reset_powerdown_n(rp_n), .unprotect_high_voltage(hv), .vpp_en(vpp));
  flash_bus_interface_control dut_u (.clk(clk), .rst(rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr(addr),
    .chip_en_n(ce_n), .out_en_n(oe_n), .wr_en_n(we_n), .latch_n(1'b0),
    .bus_clk(bclk), .adv_n(bn), .word_n(word_n), .reset_powerdown_n(rp_n),
    .unprotect_high_voltage(hv), .vpp_en(vpp), .dq_out(dq_out), .dq_oe(dq_oe),
    .valid_ready_out(vr_out), .valid_ready_oe(vr_oe), .busy_out_n(busy_n),
    .busy_oe(busy_oe), .core_rdata(core_rdata), .core_internal(1'b0),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .pe_done(pe_done),
    .mem_addr(mem_addr), .pe_start(pe_start), .pe_abort(pe_abort),
    .unprotect_all(unprot));

  task end_of_test();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task cmd(input cmd_e c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : cmd

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    logic [23:1] ea;
    int n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(dq_oe, 32'h0000_0000)
    `CHK(busy_oe, 1'b0)
    apb(1'b0, OFS_STATUS, '0);
    `CHK(rd[ST_CFG_DONE], 1'b0)
    foreach (rows[i]) begin
      ea = rows[i].w ? {rows[i].a[23:2], 1'b0} : rows[i].a;
      host_u.read_cycle(rows[i].a, rows[i].w);
      repeat (8) @(posedge clk);
      `CHK(mem_addr, ea)
      `CHK(dq_oe, rows[i].w ? 32'hffff_ffff : 32'h0000_ffff)
      `CHK(dq_out & dq_oe, {ea[16:1], ~ea[16:1]} & dq_oe)
      `CHK(vr_oe, 1'b0)
      host_u.end_cycle();
      repeat (8) @(posedge clk);
      `CHK(dq_oe, 32'h0000_0000)
    end
    apb(1'b1, OFS_CFG, 32'h0000_0000);
    apb(1'b0, OFS_STATUS, '0);
    `CHK(rd[ST_CFG_DONE], 1'b1)
    apb(1'b0, 8'h40, '0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    cmd(CMD_PROG);
    apb(1'b0, OFS_STATUS, '0);
    `CHK({starts, rd[ST_VPP_ERR]}, {32'd0, 1'b1})
    apb(1'b1, OFS_STATUS, 32'h0000_0008);
    apb(1'b0, OFS_STATUS, '0);
    `CHK(rd[ST_VPP_ERR], 1'b0)
    host_u.set_pins(1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    cmd(CMD_PROG);
    `CHK({starts, busy_oe}, {32'd1, 1'b1})
    host_u.read_cycle(23'h00_0010, 1'b1);
    repeat (8) @(posedge clk);
    `CHK(dq_oe, 32'h0000_0080)
    host_u.end_cycle();
    cmd(CMD_ERASE);
    `CHK(starts, 1)
    cmd(CMD_SUSPEND);
    `CHK(busy_oe, 1'b0)
    cmd(CMD_RESUME);
    `CHK(busy_oe, 1'b1)
    @(posedge clk);
    pe_done <= 1'b1;
    @(posedge clk);
    pe_done <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(busy_oe, 1'b0)
    cmd(CMD_PROG);
    host_u.set_pins(1'b1, 1'b0, 1'b1);
    repeat (24) @(posedge clk);
    `CHK({aborts, busy_oe, dq_oe}, {32'd1, 1'b0, 32'h0})
    host_u.set_pins(1'b1, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(unprot, 1'b1)
    host_u.set_pins(1'b1, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    `CHK(unprot, 1'b0)
    apb(1'b1, OFS_CFG, 32'h0000_0289);
    host_u.read_cycle(23'h00_0100, 1'b0);
    for (n = 0; n < 99 && vr_oe !== 1'b1; n++) @(posedge clk);
    `CHK(vr_oe, 1'b1)
    for (n = 0; n < 99 && vr_oe !== 1'b0; n++) @(posedge clk);
    `CHK(vr_oe, 1'b0)
    @(negedge bclk) @(posedge clk) bn <= 1'b0;
    repeat (3) @(negedge bclk);
    @(posedge clk) bn <= 1'b1;
    host_u.end_cycle();
    apb(1'b0, OFS_ADDR, '0);
    `CHK(rd, 32'h0000_0206)
    end_of_test();
  end
endmodule : test_flash_bus_interface_control

bind flash_bus_interface_control flash_bus_checker chk_u (.clk(clk), .rst(rst),
  .clk_en(clk_en), .pready(pready), .chip_en_n(chip_en_n), .word_n(word_n),
  .reset_powerdown_n(reset_powerdown_n), .unprotect_high_voltage(unprotect_high_voltage),
  .vpp_en(vpp_en), .dq_oe(dq_oe), .valid_ready_out(valid_ready_out),
  .busy_out_n(busy_out_n), .busy_oe(busy_oe), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .mem_addr(mem_addr), .pe_start(pe_start),
  .unprotect_all(unprotect_all));
`default_nettype wire
